// >>> hw/dcbf_consts.vh
// constants of the dual clock block memory and fifo
`ifndef DCBF_CONSTS_VH
`define DCBF_CONSTS_VH
// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define DCBF_OFS_CTRL 8'h00
`define DCBF_OFS_FULL_THR 8'h04
`define DCBF_OFS_AFULL_THR 8'h08
`define DCBF_OFS_AEMPTY_THR 8'h0c
`define DCBF_OFS_STATUS 8'h10
`define DCBF_OFS_PRE_ADDR 8'h14
`define DCBF_OFS_PRE_DATA 8'h18
// ------------------------------------------------------------
// control field positions
// ------------------------------------------------------------
`define DCBF_CTRL_SHAPE_A 2:0
`define DCBF_CTRL_SHAPE_B 5:3
`define DCBF_CTRL_MODE 7:6
`define DCBF_CTRL_WBEH 9:8
`define DCBF_CTRL_OUTREG 10
`define DCBF_CTRL_SYNCCLR 11
`define DCBF_CTRL_WLOCK 12
`define DCBF_CTRL_W 13
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define DCBF_CTRL_RST 13'h0000
`define DCBF_FULL_THR_RST 14'h03ff
`define DCBF_AFULL_THR_RST 14'h0300
`define DCBF_AEMPTY_THR_RST 14'h0100
// ------------------------------------------------------------
// modes, shapes, write behaviours
// ------------------------------------------------------------
`define DCBF_MODE_SINGLE 2'h0
`define DCBF_MODE_TRUE_DUAL 2'h1
`define DCBF_MODE_PSEUDO_DUAL 2'h2
`define DCBF_MODE_FIFO 2'h3
`define DCBF_SHAPE_8K_X1 3'h0
`define DCBF_SHAPE_4K_X2 3'h1
`define DCBF_SHAPE_2K_X4 3'h2
`define DCBF_SHAPE_1K_X9 3'h3
`define DCBF_SHAPE_512_X18 3'h4
`define DCBF_WB_NORMAL 2'h0
`define DCBF_WB_THROUGH 2'h1
`define DCBF_WB_READ_FIRST 2'h2
// ------------------------------------------------------------
// sizes
// ------------------------------------------------------------
`define DCBF_BITS 9216
`define DCBF_PRE_W 9
`endif

// >>> hw/dcbf_top.v
// block memory with single, dual, pseudo dual, rom and fifo operation
//
// What this block does
// [R1] single and true dual port in 8192x1, 4096x2, 2048x4, 1024x9 shapes
// [R2] 512x18 shape allowed only in pseudo dual and fifo operation
// [R3] ports may differ in width; bits packed lsb to msb, word by word
// [R4] contents preloadable; write lock turns the array into a rom
// [R5] inputs registered at the array; output register stage selectable
// [R6] normal: output shows read data only, unchanged on writes
// [R7] write through: written data appears on same port output
// [R8] read before write: old contents appear while new data written
// [R9] fifo write side: data, enable, strobe, tick; read side likewise
// [R10] full and almost full update only on write side ticks
// [R11] empty and almost empty update only on read side ticks
// [R12] full threshold 1..2^n-1, almost thresholds 1..full-1, empty 0
// [R13] global fifo clear resets both pointers and all flags
// [R14] replay clear resets only the read pointer
// [R15] user logic tracks packets so replay starts at valid data
// [R16] per-port output clear, synchronous or asynchronous by config
// [R17] active low chip-wide clear resets both output latches
// [R18] writes while full and reads while empty are ignored
// [R19] pointers cross sides gray coded through two flip-flops
// [R20] access only when port enable and strobe both high; memory reads need only the enable, fifo push and pop ignore the port enables
`timescale 1ns/1ps
`include "dcbf_consts.vh"

module dcbf_top
(
  input wire clk,
  input wire rst,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // port a (fifo write side)
  input wire port_a_enable,
  input wire port_a_write,
  input wire [12:0] port_a_addr,
  input wire [17:0] port_a_wdata,
  input wire port_a_output_clear,
  output wire [17:0] port_a_rdata,
  // port b (fifo read side)
  input wire port_b_enable,
  input wire port_b_write,
  input wire [12:0] port_b_addr,
  input wire [17:0] port_b_wdata,
  input wire port_b_output_clear,
  output wire [17:0] port_b_rdata,
  input wire chip_wide_clear_n,
  // fifo
  input wire write_side_clock,
  input wire write_clock_enable,
  input wire read_side_clock,
  input wire read_clock_enable,
  input wire fetch_strobe,
  input wire fifo_clear,
  input wire replay_pointer_clear,
  output reg full_flag,
  output reg almost_full_flag,
  output reg empty_flag,
  output reg almost_empty_flag
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // shape to port width
  function [4:0] shape_width;
    input [2:0] s;
    begin
      case (s)
        `DCBF_SHAPE_8K_X1: shape_width = 5'h01;
        `DCBF_SHAPE_4K_X2: shape_width = 5'h02;
        `DCBF_SHAPE_2K_X4: shape_width = 5'h04;
        `DCBF_SHAPE_512_X18: shape_width = 5'h12;
        default: shape_width = 5'h09;
      endcase
    end
  endfunction

  // address mask for shape
  function [12:0] shape_mask;
    input [2:0] s;
    begin
      case (s)
        `DCBF_SHAPE_8K_X1: shape_mask = 13'h1fff;
        `DCBF_SHAPE_4K_X2: shape_mask = 13'h0fff;
        `DCBF_SHAPE_2K_X4: shape_mask = 13'h07ff;
        `DCBF_SHAPE_512_X18: shape_mask = 13'h01ff;
        default: shape_mask = 13'h03ff;
      endcase
    end
  endfunction

  // wide shape only outside single and true dual, bad codes fall to x9
  function [2:0] eff_shape;
    input [2:0] s;
    input [1:0] m;
    begin
      if (s > `DCBF_SHAPE_512_X18)
        eff_shape = `DCBF_SHAPE_1K_X9;
      else if (s == `DCBF_SHAPE_512_X18 && m[1] == 1'b0)
        eff_shape = `DCBF_SHAPE_1K_X9; // [R2]
      else
        eff_shape = s; // [R1]
    end
  endfunction

  function [13:0] bin2gray;
    input [13:0] b;
    begin
      bin2gray = b ^ (b >> 1);
    end
  endfunction

  function [13:0] gray2bin;
    input [13:0] g;
    integer k;
    begin
      gray2bin[13] = g[13];
      for (k = 12; k >= 0; k = k - 1)
        gray2bin[k] = gray2bin[k + 1] ^ g[k];
    end
  endfunction

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg [`DCBF_CTRL_W-1:0] ctrl_r;
  reg [13:0] full_thr_r;
  reg [13:0] afull_thr_r;
  reg [13:0] aempty_thr_r;
  reg [9:0] pre_addr_r;
  reg [13:0] wptr_r;
  reg [13:0] rptr_r;
  wire [1:0] mode = ctrl_r[`DCBF_CTRL_MODE];
  wire is_fifo = (mode == `DCBF_MODE_FIFO);
  wire [2:0] shp_a = eff_shape(ctrl_r[`DCBF_CTRL_SHAPE_A], mode);
  wire [2:0] shp_b = eff_shape(ctrl_r[`DCBF_CTRL_SHAPE_B], mode);
  wire [4:0] wid_a = shape_width(shp_a); // [R3]
  wire [4:0] wid_b = shape_width(shp_b); // [R3]
  wire pre_wr = reg_wr && (reg_addr == `DCBF_OFS_PRE_DATA);

  // register writes and read data one cycle later
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r <= `DCBF_CTRL_RST;
      full_thr_r <= `DCBF_FULL_THR_RST;
      afull_thr_r <= `DCBF_AFULL_THR_RST;
      aempty_thr_r <= `DCBF_AEMPTY_THR_RST;
      pre_addr_r <= 10'h000;
      reg_rdata <= 32'h0000_0000;
    end
    else
    begin
      if (reg_wr)
      begin
        case (reg_addr)
          `DCBF_OFS_CTRL: ctrl_r <= reg_wdata[`DCBF_CTRL_W-1:0];
          `DCBF_OFS_FULL_THR: full_thr_r <= reg_wdata[13:0]; // [R12]
          `DCBF_OFS_AFULL_THR: afull_thr_r <= reg_wdata[13:0]; // [R12]
          `DCBF_OFS_AEMPTY_THR: aempty_thr_r <= reg_wdata[13:0]; // [R12]
          `DCBF_OFS_PRE_ADDR: pre_addr_r <= reg_wdata[9:0];
          `DCBF_OFS_PRE_DATA: pre_addr_r <= pre_addr_r + 10'h001;
          default: ;
        endcase
      end
      reg_rdata <= 32'h0000_0000;
      if (reg_rd)
      begin
        case (reg_addr)
          `DCBF_OFS_CTRL: reg_rdata <= {19'h00000, ctrl_r};
          `DCBF_OFS_FULL_THR: reg_rdata <= {18'h00000, full_thr_r};
          `DCBF_OFS_AFULL_THR: reg_rdata <= {18'h00000, afull_thr_r};
          `DCBF_OFS_AEMPTY_THR: reg_rdata <= {18'h00000, aempty_thr_r};
          `DCBF_OFS_STATUS: reg_rdata <= {rptr_r, wptr_r, almost_empty_flag,
            empty_flag, almost_full_flag, full_flag};
          `DCBF_OFS_PRE_ADDR: reg_rdata <= {22'h000000, pre_addr_r};
          default: reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // fifo pointers and flags
  // ------------------------------------------------------------
  reg [13:0] wgray_r;
  reg [13:0] rgray_r;
  reg [13:0] wsync1_r;
  reg [13:0] wsync2_r;
  reg [13:0] rsync1_r;
  reg [13:0] rsync2_r;
  wire [13:0] ptr_mask = {1'b0, shape_mask(shp_a)};
  wire wtick = write_side_clock && write_clock_enable; // [R9]
  wire rtick = read_side_clock && read_clock_enable; // [R9]
  wire fifo_push = is_fifo && wtick && port_a_write && !full_flag; // [R18] [R20]
  wire fifo_pop = is_fifo && rtick && fetch_strobe && !empty_flag; // [R18] [R20]
  wire [13:0] wptr_nxt = fifo_push ? wptr_r + 14'h0001 : wptr_r;
  wire [13:0] rptr_nxt = replay_pointer_clear ? 14'h0000 :
    (fifo_pop ? rptr_r + 14'h0001 : rptr_r);
  wire [13:0] wcnt_nxt = wptr_nxt - gray2bin(rsync2_r);
  wire [13:0] rcnt_nxt = gray2bin(wsync2_r) - rptr_nxt;

  // write side pointer, gray copy and flags
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wptr_r <= 14'h0000;
      wgray_r <= 14'h0000;
      rsync1_r <= 14'h0000;
      rsync2_r <= 14'h0000;
      full_flag <= 1'b0;
      almost_full_flag <= 1'b0;
    end
    else if (fifo_clear)
    begin
      wptr_r <= 14'h0000; // [R13]
      wgray_r <= 14'h0000;
      rsync1_r <= 14'h0000;
      rsync2_r <= 14'h0000;
      full_flag <= 1'b0;
      almost_full_flag <= 1'b0;
    end
    else
    begin
      rsync1_r <= rgray_r; // [R19]
      rsync2_r <= rsync1_r; // [R19]
      wptr_r <= wptr_nxt; // [R14]
      wgray_r <= bin2gray(wptr_nxt);
      if (wtick)
      begin
        full_flag <= (wcnt_nxt >= full_thr_r); // [R10] [R12]
        almost_full_flag <= (wcnt_nxt >= afull_thr_r); // [R10]
      end
    end
  end

  // read side pointer, gray copy and flags
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rptr_r <= 14'h0000;
      rgray_r <= 14'h0000;
      wsync1_r <= 14'h0000;
      wsync2_r <= 14'h0000;
      empty_flag <= 1'b1;
      almost_empty_flag <= 1'b1;
    end
    else if (fifo_clear)
    begin
      rptr_r <= 14'h0000; // [R13]
      rgray_r <= 14'h0000;
      wsync1_r <= 14'h0000;
      wsync2_r <= 14'h0000;
      empty_flag <= 1'b1;
      almost_empty_flag <= 1'b1;
    end
    else
    begin
      wsync1_r <= wgray_r; // [R19]
      wsync2_r <= wsync1_r; // [R19]
      rptr_r <= rptr_nxt; // [R14]
      rgray_r <= bin2gray(rptr_nxt);
      if (rtick)
      begin
        empty_flag <= (rcnt_nxt == 14'h0000); // [R11] [R12]
        almost_empty_flag <= (rcnt_nxt <= aempty_thr_r); // [R11]
      end
    end
  end

  // ------------------------------------------------------------
  // input capture stage
  // ------------------------------------------------------------
  reg a_en_r;
  reg a_we_r;
  reg [12:0] a_addr_r;
  reg [17:0] a_din_r;
  reg b_en_r;
  reg b_we_r;
  reg [12:0] b_addr_r;
  reg [17:0] b_din_r;
  wire wlock = ctrl_r[`DCBF_CTRL_WLOCK];
  wire b_live = (mode != `DCBF_MODE_SINGLE);

  // fifo steers the ports from its pointers
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      a_en_r <= 1'b0;
      a_we_r <= 1'b0;
      a_addr_r <= 13'h0000;
      a_din_r <= 18'h00000;
      b_en_r <= 1'b0;
      b_we_r <= 1'b0;
      b_addr_r <= 13'h0000;
      b_din_r <= 18'h00000;
    end
    else
    begin
      a_din_r <= port_a_wdata; // [R5]
      b_din_r <= port_b_wdata; // [R5]
      if (is_fifo)
      begin
        a_en_r <= fifo_push;
        a_we_r <= fifo_push && !wlock;
        a_addr_r <= wptr_r[12:0] & ptr_mask[12:0];
        b_en_r <= fifo_pop;
        b_we_r <= 1'b0;
        b_addr_r <= rptr_r[12:0] & ptr_mask[12:0];
      end
      else
      begin
        a_en_r <= port_a_enable; // [R20]
        a_we_r <= port_a_enable && port_a_write && !wlock; // [R4] [R20]
        a_addr_r <= port_a_addr & shape_mask(shp_a); // [R5]
        b_en_r <= b_live && port_b_enable; // [R20]
        b_we_r <= (mode == `DCBF_MODE_TRUE_DUAL) && port_b_enable
          && port_b_write && !wlock; // [R4] [R20]
        b_addr_r <= port_b_addr & shape_mask(shp_b); // [R5]
      end
    end
  end

  // ------------------------------------------------------------
  // storage array, bit addressed
  // ------------------------------------------------------------
  reg mem [0:`DCBF_BITS-1];
  wire [13:0] a_base = {1'b0, a_addr_r} * {9'h000, wid_a}; // [R3]
  wire [13:0] b_base = {1'b0, b_addr_r} * {9'h000, wid_b}; // [R3]
  wire [31:0] p_prod = pre_addr_r * `DCBF_PRE_W; // [R4]
  wire [13:0] p_base = p_prod[13:0]; // highest index stays below 9216
  integer i;

  // gather one word of given width from the bit array
  function [17:0] read_word;
    input [13:0] base;
    input [4:0] w;
    integer j;
    begin
      read_word = 18'h00000;
      for (j = 0; j < 18; j = j + 1)
        if (j < w)
          read_word[j] = mem[base + j];
    end
  endfunction

  // preload first, then port a, then port b
  always @(posedge clk)
  begin
    for (i = 0; i < 18; i = i + 1)
    begin
      if (pre_wr && i < `DCBF_PRE_W)
        mem[p_base + i] <= reg_wdata[i]; // [R4]
      else if (a_we_r && i < wid_a)
        mem[a_base + i] <= a_din_r[i]; // [R3]
      else if (b_we_r && i < wid_b)
        mem[b_base + i] <= b_din_r[i];
    end
  end

  // ------------------------------------------------------------
  // output latches and optional output register
  // ------------------------------------------------------------
  wire [1:0] wbeh = ctrl_r[`DCBF_CTRL_WBEH];
  wire outreg = ctrl_r[`DCBF_CTRL_OUTREG];
  wire syncclr = ctrl_r[`DCBF_CTRL_SYNCCLR];
  wire a_aclr = rst || !chip_wide_clear_n || (port_a_output_clear && !syncclr); // [R16] [R17]
  wire b_aclr = rst || !chip_wide_clear_n || (port_b_output_clear && !syncclr); // [R16] [R17]
  reg [17:0] a_lat_r;
  reg [17:0] a_pipe_r;
  reg [17:0] b_lat_r;
  reg [17:0] b_pipe_r;
  assign port_a_rdata = outreg ? a_pipe_r : a_lat_r; // [R5]
  assign port_b_rdata = outreg ? b_pipe_r : b_lat_r; // [R5]

  // next latch value by write behaviour
  function [17:0] lat_nxt;
    input en;
    input we;
    input [17:0] old;
    input [17:0] rd;
    input [17:0] wd;
    input [1:0] beh;
    begin
      if (!en)
        lat_nxt = old;
      else if (!we)
        lat_nxt = rd;
      else if (beh == `DCBF_WB_THROUGH)
        lat_nxt = wd; // [R7]
      else if (beh == `DCBF_WB_READ_FIRST)
        lat_nxt = rd; // [R8]
      else
        lat_nxt = old; // [R6]
    end
  endfunction

  // port a output latch
  always @(posedge clk or posedge a_aclr)
  begin
    if (a_aclr)
    begin
      a_lat_r <= 18'h00000;
      a_pipe_r <= 18'h00000;
    end
    else if (port_a_output_clear)
    begin
      a_lat_r <= 18'h00000; // [R16]
      a_pipe_r <= 18'h00000;
    end
    else
    begin
      a_lat_r <= lat_nxt(a_en_r, a_we_r, a_lat_r, read_word(a_base, wid_a),
        a_din_r & ~(18'h3ffff << wid_a), wbeh);
      a_pipe_r <= a_lat_r;
    end
  end

  // port b output latch
  always @(posedge clk or posedge b_aclr)
  begin
    if (b_aclr)
    begin
      b_lat_r <= 18'h00000;
      b_pipe_r <= 18'h00000;
    end
    else if (port_b_output_clear)
    begin
      b_lat_r <= 18'h00000; // [R16]
      b_pipe_r <= 18'h00000;
    end
    else
    begin
      b_lat_r <= lat_nxt(b_en_r, b_we_r, b_lat_r, read_word(b_base, wid_b),
        b_din_r & ~(18'h3ffff << wid_b), wbeh);
      b_pipe_r <= b_lat_r;
    end
  end

endmodule // dcbf_top

// >>> testbench/dcbf_monitor.sv
// assertion checker watching the top ports of the block memory
`timescale 1ns/1ps
module dcbf_monitor
(
  input wire clk,
  input wire rst,
  input wire port_a_output_clear,
  input wire [17:0] port_a_rdata,
  input wire port_b_output_clear,
  input wire [17:0] port_b_rdata,
  input wire chip_wide_clear_n,
  input wire write_side_clock,
  input wire read_side_clock,
  input wire fifo_clear,
  input wire full_flag,
  input wire almost_full_flag,
  input wire empty_flag,
  input wire almost_empty_flag
);
  // --------------------------------------------
  // flag timing and output clears
  // --------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_full_wside_only:
    assert property ($changed(full_flag) |-> $past(write_side_clock) || $past(fifo_clear))
    else $error("full flag moved without a write tick");
  a_afull_wside_only:
    assert property ($changed(almost_full_flag) |-> $past(write_side_clock) || $past(fifo_clear))
    else $error("almost full flag moved without a write tick");
  a_empty_rside_only:
    assert property ($changed(empty_flag) |-> $past(read_side_clock) || $past(fifo_clear))
    else $error("empty flag moved without a read tick");
  a_aempty_rside_only:
    assert property ($changed(almost_empty_flag) |-> $past(read_side_clock) || $past(fifo_clear))
    else $error("almost empty flag moved without a read tick");
  a_clear_flags_reset:
    assert property (fifo_clear |=> empty_flag && almost_empty_flag && !full_flag
      && !almost_full_flag)
    else $error("flags not back at reset state after fifo clear");
  a_chip_clear_both:
    assert property (!chip_wide_clear_n |-> port_a_rdata == 18'h0 && port_b_rdata == 18'h0)
    else $error("output not zero under chip clear");
  a_local_clear_a:
    assert property (port_a_output_clear [*2] |-> port_a_rdata == 18'h0)
    else $error("port a output not cleared");
  a_local_clear_b:
    assert property (port_b_output_clear [*2] |-> port_b_rdata == 18'h0)
    else $error("port b output not cleared");
  c_full_reached: cover property ($rose(full_flag));
  c_empty_left: cover property ($fell(empty_flag));
  c_fifo_cleared: cover property (fifo_clear ##1 empty_flag);
endmodule // dcbf_monitor

bind dcbf_top dcbf_monitor mon_u
(
  .clk(clk), .rst(rst), .port_a_output_clear(port_a_output_clear),
  .port_a_rdata(port_a_rdata), .port_b_output_clear(port_b_output_clear),
  .port_b_rdata(port_b_rdata), .chip_wide_clear_n(chip_wide_clear_n),
  .write_side_clock(write_side_clock), .read_side_clock(read_side_clock),
  .fifo_clear(fifo_clear), .full_flag(full_flag), .almost_full_flag(almost_full_flag),
  .empty_flag(empty_flag), .almost_empty_flag(almost_empty_flag)
);

// >>> testbench/dcbf_fabric.sv
// fabric model making the fifo write and read side ticks
`timescale 1ns/1ps
module dcbf_fabric
(
  input wire clk,
  input wire rst,
  input wire slow,
  output reg write_side_clock,
  output reg write_clock_enable,
  output reg read_side_clock,
  output reg read_clock_enable
);
  reg [2:0] cnt_r;
  // --------------------------------------------
  // tick generation
  // --------------------------------------------
  // each side ticks and qualifies on its own pattern when slow
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= 3'h0;
      write_side_clock <= 1'b0;
      write_clock_enable <= 1'b0;
      read_side_clock <= 1'b0;
      read_clock_enable <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_r + 3'h1;
      write_side_clock <= !slow || cnt_r[0];
      write_clock_enable <= !slow || (cnt_r != 3'h3);
      read_side_clock <= !slow || cnt_r[1];
      read_clock_enable <= !slow || !cnt_r[2];
    end
  end
endmodule // dcbf_fabric

// >>> testbench/test_dcbf_top.sv
// self-checking bench for the block memory and fifo
`timescale 1ns/1ps
`include "dcbf_consts.vh"
module test_dcbf_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg slow = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg port_a_enable = 1'b0;
  reg port_a_write = 1'b0;
  reg [12:0] port_a_addr = 13'h0;
  reg [17:0] port_a_wdata = 18'h0;
  reg port_a_output_clear = 1'b0;
  reg port_b_enable = 1'b0;
  reg [12:0] port_b_addr = 13'h0;
  reg port_b_output_clear = 1'b0;
  reg chip_wide_clear_n = 1'b1;
  reg fetch_strobe = 1'b0;
  reg fifo_clear = 1'b0;
  reg replay_pointer_clear = 1'b0;
  reg [31:0] rv;
  reg ok;
  integer errors = 0;
  integer checked = 0;
  wire [31:0] reg_rdata;
  wire [17:0] port_a_rdata;
  wire [17:0] port_b_rdata;
  wire write_side_clock, write_clock_enable, read_side_clock, read_clock_enable;
  wire full_flag, almost_full_flag, empty_flag, almost_empty_flag;
  // --------------------------------------------
  // clock, design and fabric
  // --------------------------------------------
  always #50 clk = ~clk;
  dcbf_top dut_u
  (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_a_enable(port_a_enable),
    .port_a_write(port_a_write), .port_a_addr(port_a_addr), .port_a_wdata(port_a_wdata),
    .port_a_output_clear(port_a_output_clear), .port_a_rdata(port_a_rdata),
    .port_b_enable(port_b_enable), .port_b_write(1'b0), .port_b_addr(port_b_addr),
    .port_b_wdata(18'h0), .port_b_output_clear(port_b_output_clear),
    .port_b_rdata(port_b_rdata), .chip_wide_clear_n(chip_wide_clear_n),
    .write_side_clock(write_side_clock), .write_clock_enable(write_clock_enable),
    .read_side_clock(read_side_clock), .read_clock_enable(read_clock_enable),
    .fetch_strobe(fetch_strobe), .fifo_clear(fifo_clear),
    .replay_pointer_clear(replay_pointer_clear), .full_flag(full_flag),
    .almost_full_flag(almost_full_flag), .empty_flag(empty_flag),
    .almost_empty_flag(almost_empty_flag)
  );
  dcbf_fabric fab_u
  (
    .clk(clk), .rst(rst), .slow(slow), .write_side_clock(write_side_clock),
    .write_clock_enable(write_clock_enable), .read_side_clock(read_side_clock),
    .read_clock_enable(read_clock_enable)
  );
  // --------------------------------------------
  // shared tasks
  // --------------------------------------------
  task chk(input [31:0] seen, input [31:0] exp);
    checked = checked + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task stop_test;
    if (errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask
  // one memory access, output judged two edges after it is taken
  task macc(input pb, input we, input en, input [12:0] ad, input [17:0] d, input [17:0] exp);
    @(posedge clk);
    port_a_enable <= en & !pb;
    port_b_enable <= en & pb;
    port_a_write <= we;
    port_a_addr <= ad;
    port_b_addr <= ad;
    port_a_wdata <= d;
    @(posedge clk);
    port_a_enable <= 1'b0;
    port_b_enable <= 1'b0;
    port_a_write <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({14'h0, pb ? port_b_rdata : port_a_rdata}, {14'h0, exp});
  endtask
  // bounded wait for a tick edge of the side; a read edge also needs the fifo not empty
  task wait_tick(input ws);
    integer i;
    ok = 1'b0;
    for (i = 0; i < 40 && !ok; i = i + 1)
    begin
      @(posedge clk);
      ok = ws ? (write_side_clock && write_clock_enable)
              : (read_side_clock && read_clock_enable && !empty_flag);
    end
    if (!ok)
    begin
      errors = errors + 1;
      stop_test;
    end
  endtask
  task push(input [17:0] d);
    @(posedge clk);
    port_a_wdata <= d;
    port_a_write <= 1'b1;
    wait_tick(1'b1);
    port_a_write <= 1'b0;
  endtask
  task pop(input [17:0] exp);
    @(posedge clk);
    fetch_strobe <= 1'b1;
    wait_tick(1'b0);
    fetch_strobe <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({14'h0, port_b_rdata}, {14'h0, exp});
  endtask
  // --------------------------------------------
  // scenarios
  // --------------------------------------------
  task t_regs;
    rd(`DCBF_OFS_CTRL);
    chk(rv, 32'h0);
    rd(`DCBF_OFS_FULL_THR);
    chk(rv, {18'h0, `DCBF_FULL_THR_RST});
    rd(`DCBF_OFS_AFULL_THR);
    chk(rv, {18'h0, `DCBF_AFULL_THR_RST});
    rd(`DCBF_OFS_AEMPTY_THR);
    chk(rv, {18'h0, `DCBF_AEMPTY_THR_RST});
    wr(`DCBF_OFS_STATUS, 32'hffffffff);
    rd(`DCBF_OFS_STATUS);
    chk(rv, 32'h0000000c);
    rd(8'h20);
    chk(rv, 32'h0);
  endtask
  task t_mem;
    integer i;
    wr(`DCBF_OFS_CTRL, 32'h3);
    macc(1'b0, 1'b1, 1'b1, 13'h5, 18'h1a5, 18'h0);
    macc(1'b0, 1'b0, 1'b1, 13'h5, 18'h0, 18'h1a5);
    macc(1'b0, 1'b1, 1'b0, 13'h5, 18'h0ff, 18'h1a5);
    macc(1'b0, 1'b1, 1'b1, 13'h6, 18'h0f3, 18'h1a5);
    macc(1'b0, 1'b0, 1'b1, 13'h5, 18'h0, 18'h1a5);
    wr(`DCBF_OFS_CTRL, 32'h103);
    macc(1'b0, 1'b1, 1'b1, 13'h7, 18'h055, 18'h055);
    wr(`DCBF_OFS_CTRL, 32'h203);
    macc(1'b0, 1'b1, 1'b1, 13'h7, 18'h0aa, 18'h055);
    wr(`DCBF_OFS_CTRL, 32'h5b);
    macc(1'b1, 1'b0, 1'b1, 13'h7, 18'h0, 18'h0aa);
    wr(`DCBF_OFS_CTRL, 32'h9c);
    macc(1'b0, 1'b1, 1'b1, 13'h2, 18'h34aa5, 18'h055);
    macc(1'b1, 1'b0, 1'b1, 13'h4, 18'h0, 18'h0a5);
    macc(1'b1, 1'b0, 1'b1, 13'h5, 18'h0, 18'h1a5);
    wr(`DCBF_OFS_CTRL, 32'h0);
    for (i = 0; i < 9; i = i + 1)
      macc(1'b0, 1'b0, 1'b1, 13'd45 + i[12:0], 18'h0, (18'h1a5 >> i) & 18'h1);
  endtask
  task t_rom;
    wr(`DCBF_OFS_PRE_ADDR, 32'h0);
    wr(`DCBF_OFS_PRE_DATA, 32'h133);
    wr(`DCBF_OFS_PRE_DATA, 32'h0c7);
    wr(`DCBF_OFS_CTRL, 32'h1003);
    macc(1'b0, 1'b1, 1'b1, 13'h0, 18'h0, 18'h133);
    macc(1'b0, 1'b0, 1'b1, 13'h0, 18'h0, 18'h133);
    macc(1'b0, 1'b0, 1'b1, 13'h1, 18'h0, 18'h0c7);
  endtask
  task t_clear;
    wr(`DCBF_OFS_CTRL, 32'h803);
    @(posedge clk);
    chip_wide_clear_n <= 1'b0;
    @(posedge clk);
    #1;
    chk({14'h0, port_a_rdata}, 32'h0);
    chk({14'h0, port_b_rdata}, 32'h0);
    @(posedge clk);
    chip_wide_clear_n <= 1'b1;
    macc(1'b0, 1'b0, 1'b1, 13'h1, 18'h0, 18'h0c7);
    @(posedge clk);
    port_a_output_clear <= 1'b1;
    port_b_output_clear <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({14'h0, port_a_rdata}, 32'h0);
    @(posedge clk);
    port_a_output_clear <= 1'b0;
    port_b_output_clear <= 1'b0;
    wr(`DCBF_OFS_CTRL, 32'h403);
    macc(1'b0, 1'b0, 1'b1, 13'h1, 18'h0, 18'h0c7);
    @(posedge clk);
    port_a_output_clear <= 1'b1;
    #1;
    chk({14'h0, port_a_rdata}, 32'h0);
    @(posedge clk);
    port_a_output_clear <= 1'b0;
  endtask
  task t_fifo;
    integer i;
    @(posedge clk);
    slow <= 1'b1;
    wr(`DCBF_OFS_CTRL, 32'hdb);
    wr(`DCBF_OFS_FULL_THR, 32'h4);
    wr(`DCBF_OFS_AFULL_THR, 32'h3);
    wr(`DCBF_OFS_AEMPTY_THR, 32'h1);
    for (i = 0; i < 4; i = i + 1)
      push(18'h101 + i[17:0]);
    for (i = 0; i < 40 && full_flag !== 1'b1; i = i + 1)
      @(posedge clk);
    chk({31'h0, full_flag}, 32'h1);
    if (i == 40)
      stop_test;
    push(18'h1ff);
    rd(`DCBF_OFS_STATUS);
    chk(rv & 32'hfffffff3, 32'h00000043);
    pop(18'h101);
    pop(18'h102);
    chk({30'h0, almost_empty_flag, empty_flag}, 32'h0);
    @(posedge clk);
    replay_pointer_clear <= 1'b1;
    @(posedge clk);
    replay_pointer_clear <= 1'b0;
    rd(`DCBF_OFS_STATUS);
    chk(rv & 32'hfffffff0, 32'h00000040);
    pop(18'h101);
    @(posedge clk);
    fifo_clear <= 1'b1;
    @(posedge clk);
    fifo_clear <= 1'b0;
    rd(`DCBF_OFS_STATUS);
    chk(rv, 32'h0000000c);
    @(posedge clk);
    fetch_strobe <= 1'b1;
    repeat (6) @(posedge clk);
    fetch_strobe <= 1'b0;
    rd(`DCBF_OFS_STATUS);
    chk(rv, 32'h0000000c);
  endtask
  // --------------------------------------------
  // main sequence
  // --------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_mem;
    t_rom;
    t_clear;
    t_fifo;
    stop_test;
  end
endmodule // test_dcbf_top
